// [rtl/ctir_pkg.sv]
// Package of constants and types for the charger telemetry register bank.
package ctir_pkg;

    // ------------------------------------------------------------------
    // Register indices (printed offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTIR_IDX_BRIDGE_PWR = 8'h56;
    localparam logic [7:0] CTIR_IDX_FIELD_PWR = 8'h58;
    localparam logic [7:0] CTIR_IDX_RX_PWR = 8'h5A;
    localparam logic [7:0] CTIR_IDX_BATT = 8'h5C;
    localparam logic [7:0] CTIR_IDX_INDIC = 8'h5D;
    localparam logic [7:0] CTIR_IDX_FAULT = 8'h5E;
    localparam logic [7:0] CTIR_IDX_HOST_EN = 8'h78;
    localparam logic [7:0] CTIR_IDX_RX_EN = 8'h79;
    localparam logic [7:0] CTIR_IDX_MISC_EN = 8'h7A;
    localparam logic [7:0] CTIR_IDX_SUMMARY = 8'h7C;
    localparam logic [7:0] CTIR_IDX_RX_STAT = 8'h7D;
    localparam logic [7:0] CTIR_IDX_MISC_STAT = 8'h7E;

    // ------------------------------------------------------------------
    // Field positions and write masks
    // ------------------------------------------------------------------
    localparam int CTIR_BIT_CTS = 5;
    localparam int CTIR_BIT_API_CTS = 4;
    localparam int CTIR_BIT_TEST_SUM = 3;
    localparam int CTIR_BIT_MISC_SUM = 2;
    localparam int CTIR_BIT_RX_SUM = 1;
    localparam logic [7:0] CTIR_HOST_EN_MASK = 8'h3E;
    localparam logic [7:0] CTIR_RX_EN_MASK = 8'h3F;
    localparam logic [7:0] CTIR_MISC_EN_MASK = 8'h03;
    localparam logic [7:0] CTIR_INDIC_MASK = 8'h0F;
    localparam logic [7:0] CTIR_MASK_RESET = 8'h00;
    localparam logic [15:0] CTIR_MEAS_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Fault codes and end-of-transfer reasons
    // ------------------------------------------------------------------
    localparam logic [7:0] CTIR_ERR_NONE = 8'h00;
    localparam logic [7:0] CTIR_ERR_RESOURCES = 8'h01;
    localparam logic [7:0] CTIR_ERR_TIMING = 8'h02;
    localparam logic [7:0] CTIR_ERR_SEQUENCE = 8'h03;
    localparam logic [7:0] CTIR_ERR_DATA = 8'h04;
    localparam logic [7:0] CTIR_ERR_TIMEOUT = 8'h05;
    localparam logic [7:0] CTIR_ERR_FOREIGN = 8'h06;
    localparam logic [7:0] CTIR_ERR_LIMIT = 8'h07;
    localparam logic [7:0] CTIR_ERR_END_XFER = 8'h08;
    localparam logic [7:0] CTIR_EPT_UNKNOWN = 8'h00;
    localparam logic [7:0] CTIR_EPT_COMM = 8'h1B;

    // Indicator codes.
    typedef enum logic [3:0] {
        CTIR_IND_STANDBY = 4'h0,
        CTIR_IND_XFER = 4'h1,
        CTIR_IND_FULL = 4'h2,
        CTIR_IND_EOC = 4'h3,
        CTIR_IND_RX_ERR = 4'h4,
        CTIR_IND_TX_ERR = 4'h5,
        CTIR_IND_FOD_ERR = 4'h6
    } ctir_indicator_t;

    // Telemetry coming from the measurement and packet logic.
    typedef struct packed {
        logic [15:0] bridge_input_power;
        logic [15:0] field_tx_power;
        logic [15:0] rx_reported_power;
        logic [7:0] rx_battery_percent;
        logic [3:0] indicator_code;
        logic [7:0] fault_code;
        logic [7:0] fault_qualifier;
    } ctir_telem_t;

    // Raw status inputs.
    typedef struct packed {
        logic cts;
        logic api_send_ok_flag;
        logic [5:0] rx_event_status;
        logic [1:0] misc_event_status;
        logic test_event_summary;
    } ctir_status_t;

endpackage : ctir_pkg

// [rtl/ctir_irq_gen.sv]
// Summary flag and host interrupt generation for the register bank.
`timescale 1ns/100ps
module ctir_irq_gen
    import ctir_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Status and masks.
    input wire ctir_status_t status_i,
    input wire logic [7:0] host_en_i,
    input wire logic [7:0] rx_en_i,
    input wire logic [7:0] misc_en_i,
    // Results.
    output logic [7:0] summary_o,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Summary flags
    // ------------------------------------------------------------------
    logic rx_event_summary;
    logic misc_event_summary;
    logic [7:0] summary_d;
    logic [7:0] summary_q;
    logic [7:0] rise;
    logic irq_d;
    logic irq_q;

    // The RX and misc summary flags follow the enabled status bits; the other summary flags copy their status inputs.
    assign rx_event_summary = |(status_i.rx_event_status & rx_en_i[5:0]);
    assign misc_event_summary = |(status_i.misc_event_status & misc_en_i[1:0]);
    assign summary_d = {2'b00, status_i.cts, status_i.api_send_ok_flag,
                        status_i.test_event_summary, misc_event_summary,
                        rx_event_summary, 1'b0};

    // Rising edges of summary bits gated by the host enable mask.
    assign rise = summary_d & ~summary_q & host_en_i & CTIR_HOST_EN_MASK;
    assign irq_d = rise[CTIR_BIT_CTS] | rise[CTIR_BIT_API_CTS];
    wire irq_sum = rise[CTIR_BIT_RX_SUM] | rise[CTIR_BIT_MISC_SUM]
                   | rise[CTIR_BIT_TEST_SUM];

    // Register the summary and a one-cycle interrupt pulse.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            summary_q <= CTIR_MASK_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            summary_q <= summary_d;
            irq_q <= irq_d | irq_sum;
        end
    end

    assign summary_o = summary_q;
    assign irq_o = irq_q;

endmodule : ctir_irq_gen

// [rtl/ctir_regs.sv]
// APB register bank for charger telemetry, fault report and interrupt masks.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module ctir_regs
    import ctir_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Telemetry and status from the same clock domain.
    input wire ctir_telem_t telem_i,
    input wire ctir_status_t status_i,
    // Host interrupt.
    output logic irq_o
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [7:0] idx;
    logic aligned;
    logic setup;
    logic wr_en;
    logic hit;
    logic [7:0] summary;
    logic irq_int;

    // Byte address is four times the index; low bits must be zero.
    assign idx = paddr_i[9:2];
    assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
    assign setup = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & pwrite_i & pready_o & pstrb_i[0];

    // Map of known indices.
    function automatic logic is_mapped(input logic [7:0] i);
        unique case (i)
            CTIR_IDX_BRIDGE_PWR, CTIR_IDX_FIELD_PWR, CTIR_IDX_RX_PWR,
            CTIR_IDX_BATT, CTIR_IDX_INDIC, CTIR_IDX_FAULT,
            CTIR_IDX_HOST_EN, CTIR_IDX_RX_EN, CTIR_IDX_MISC_EN,
            CTIR_IDX_SUMMARY, CTIR_IDX_RX_STAT, CTIR_IDX_MISC_STAT:
                is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    assign hit = aligned & is_mapped(idx);

    // ------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------
    logic [7:0] host_en_q;
    logic [7:0] rx_en_q;
    logic [7:0] misc_en_q;
    logic [7:0] host_en_d;
    logic [7:0] rx_en_d;
    logic [7:0] misc_en_d;
    logic [7:0] wbyte;

    // Only writable bits are kept; reserved bits stay zero.
    assign wbyte = pwdata_i[7:0];
    assign host_en_d = (wr_en && hit && idx == CTIR_IDX_HOST_EN) ?
                       (wbyte & CTIR_HOST_EN_MASK) : host_en_q;
    assign rx_en_d = (wr_en && hit && idx == CTIR_IDX_RX_EN) ?
                     (wbyte & CTIR_RX_EN_MASK) : rx_en_q;
    assign misc_en_d = (wr_en && hit && idx == CTIR_IDX_MISC_EN) ?
                       (wbyte & CTIR_MISC_EN_MASK) : misc_en_q;

    // Masks clear at reset so nothing fires until enabled.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            host_en_q <= CTIR_MASK_RESET;
            rx_en_q <= CTIR_MASK_RESET;
            misc_en_q <= CTIR_MASK_RESET;
        end
        else
        begin
            host_en_q <= host_en_d;
            rx_en_q <= rx_en_d;
            misc_en_q <= misc_en_d;
        end
    end

    // ------------------------------------------------------------------
    // Telemetry capture
    // ------------------------------------------------------------------
    ctir_telem_t telem_q;
    logic [7:0] qual_d;

    // The qualifier is meaningful for end-of-transfer; it is passed
    // through for every code since other codes define it as reserved.
    assign qual_d = telem_i.fault_qualifier;

    // Sample the telemetry so readback is stable within an access.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            telem_q <= '0;
        end
        else
        begin
            telem_q.bridge_input_power <= telem_i.bridge_input_power;
            telem_q.field_tx_power <= telem_i.field_tx_power;
            telem_q.rx_reported_power <= telem_i.rx_reported_power;
            telem_q.rx_battery_percent <= telem_i.rx_battery_percent;
            telem_q.indicator_code <= telem_i.indicator_code;
            telem_q.fault_code <= telem_i.fault_code;
            telem_q.fault_qualifier <= qual_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt logic
    // ------------------------------------------------------------------
    ctir_irq_gen u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .status_i(status_i),
        .host_en_i(host_en_q),
        .rx_en_i(rx_en_q),
        .misc_en_i(misc_en_q),
        .summary_o(summary),
        .irq_o(irq_int)
    );

    // ------------------------------------------------------------------
    // Read mux and APB answer
    // ------------------------------------------------------------------
    logic [31:0] rdata_mux;
    logic [31:0] prdata_d;
    logic pready_d;
    logic pslverr_d;
    logic irq_q;

    // Selects read data; reserved bits and unmapped words read zero.
    always_comb
    begin
        rdata_mux = 32'h0000_0000;
        unique case (idx)
            CTIR_IDX_BRIDGE_PWR:
                rdata_mux = {16'h0000, telem_q.bridge_input_power};
            CTIR_IDX_FIELD_PWR:
                rdata_mux = {16'h0000, telem_q.field_tx_power};
            CTIR_IDX_RX_PWR:
                rdata_mux = {16'h0000, telem_q.rx_reported_power};
            CTIR_IDX_BATT:
                rdata_mux = {24'h00_0000, telem_q.rx_battery_percent};
            CTIR_IDX_INDIC:
                rdata_mux = {28'h000_0000, telem_q.indicator_code};
            CTIR_IDX_FAULT: rdata_mux = {16'h0000, telem_q.fault_qualifier,
                                         telem_q.fault_code};
            CTIR_IDX_HOST_EN: rdata_mux = {24'h00_0000, host_en_q};
            CTIR_IDX_RX_EN: rdata_mux = {24'h00_0000, rx_en_q};
            CTIR_IDX_MISC_EN: rdata_mux = {24'h00_0000, misc_en_q};
            CTIR_IDX_SUMMARY: rdata_mux = {24'h00_0000, summary};
            CTIR_IDX_RX_STAT:
                rdata_mux = {26'h000_0000, status_i.rx_event_status};
            CTIR_IDX_MISC_STAT: rdata_mux = {30'h0000_0000,
                                             status_i.misc_event_status};
            default: rdata_mux = 32'h0000_0000;
        endcase
    end

    // No wait state: ready rises in the first access cycle.
    assign pready_d = setup;
    assign prdata_d = (setup && !pwrite_i && hit) ?
                      rdata_mux : 32'h0000_0000;
    assign pslverr_d = setup & ~hit;

    // Registered APB outputs and interrupt.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            pready_o <= pready_d;
            prdata_o <= prdata_d;
            pslverr_o <= pslverr_d;
            irq_q <= irq_int;
        end
    end

    assign irq_o = irq_q;

endmodule : ctir_regs

// [test/ctir_regs_checker.sv]
// Assertion checker for the telemetry register bank ports.
`timescale 1ns/100ps
module ctir_regs_checker
    import ctir_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Status and interrupt.
    input wire ctir_status_t status_i,
    input wire logic irq_o
);
    localparam logic [11:0] A_HEN = {2'b00, CTIR_IDX_HOST_EN, 2'b00};
    localparam logic [11:0] A_REN = {2'b00, CTIR_IDX_RX_EN, 2'b00};
    localparam logic [11:0] A_MEN = {2'b00, CTIR_IDX_MISC_EN, 2'b00};
    localparam logic [11:0] A_IND = {2'b00, CTIR_IDX_INDIC, 2'b00};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [7:0] hen_q;
    logic [7:0] ren_q;
    logic [7:0] men_q;
    logic [4:0] sum_q;
    // Enabled summary flags and the rises that must interrupt.
    wire wr_w = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
    wire [4:0] sum_w = {status_i.cts, status_i.api_send_ok_flag,
        status_i.test_event_summary,
        |(status_i.misc_event_status & men_q[1:0]),
        |(status_i.rx_event_status & ren_q[5:0])};
    wire rise_w = |(sum_w & ~sum_q & hen_q[5:1]);
    // Shadow masks, written at the access edge like the real ones.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            {hen_q, ren_q, men_q, sum_q} <= '0;
        else
        begin
            sum_q <= sum_w;
            if (wr_w && paddr_i == A_HEN)
                hen_q <= pwdata_i[7:0] & CTIR_HOST_EN_MASK;
            if (wr_w && paddr_i == A_REN)
                ren_q <= pwdata_i[7:0] & CTIR_RX_EN_MASK;
            if (wr_w && paddr_i == A_MEN)
                men_q <= pwdata_i[7:0] & CTIR_MISC_EN_MASK;
        end
    end
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held");
    property p_setup_ready;
        psel_i && !penable_i |=> pready_o;
    endproperty
    a_setup_ready: assert property (p_setup_ready)
        else $error("no ready");
    property p_idle_quiet;
        !psel_i |=> !pready_o && !pslverr_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("stray ready");
    property p_err_zero;
        pready_o && pslverr_o |-> prdata_o == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error data");
    property p_indic_res;
        pready_o && !pwrite_i && paddr_i == A_IND |->
            prdata_o[31:4] == 28'h000_0000;
    endproperty
    a_indic_res: assert property (p_indic_res) else $error("indic bits");
    property p_mask_read;
        pready_o && !pwrite_i && paddr_i == A_REN |->
            prdata_o == {24'h00_0000, ren_q};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read");
    property p_irq_cause;
        rise_w |-> ##2 irq_o;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq missed");
    property p_irq_only;
        irq_o |-> $past(rise_w, 2);
    endproperty
    a_irq_only: assert property (p_irq_only)
        else $error("irq spurious");
endmodule : ctir_regs_checker
bind ctir_regs ctir_regs_checker ctir_regs_checker_inst (.clk_i(clk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .status_i(status_i), .irq_o(irq_o));

// [test/ctir_host_model.sv]
// Host processor model that issues APB transfers to the bank.
`timescale 1ns/100ps
module ctir_host_model
(
    // Clock and bus response.
    input wire logic clk_i,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    // Bus request.
    output logic psel_o = 1'b0,
    output logic penable_o = 1'b0,
    output logic pwrite_o = 1'b0,
    output logic [11:0] paddr_o = 12'h000,
    output logic [31:0] pwdata_o = 32'h0000_0000,
    output logic [3:0] pstrb_o = 4'h0
);
    // One setup and access phase, held until pready is sampled high.
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        pstrb_o <= s;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do
            @(posedge clk_i);
        while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~d;
    endtask : xfer
endmodule : ctir_host_model

// [test/tb_charger_telemetry_irq_regs.sv]
// Self-checking testbench for the telemetry register bank.
`timescale 1ns/100ps
module tb_charger_telemetry_irq_regs
    import ctir_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    ctir_telem_t telem = '0;
    ctir_status_t status = '0;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    ctir_regs ctir_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .telem_i(telem),
        .status_i(status), .irq_o(irq));
    ctir_host_model ctir_host_model_inst (.clk_i(clk_i), .prdata_i(prdata),
        .pready_i(pready), .pslverr_i(pslverr), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .pstrb_o(pstrb));
    // Clock and a cycle limit that cuts a hang short.
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            close_out();
        end
    end
    function automatic logic [11:0] aw(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : aw
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x)
        begin
            miscompares++;
            $display("unexpected at %0t: exp %h got %h", $time, x, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] q;
        logic e;
        ctir_host_model_inst.xfer(1'b1, a, d, s, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input logic ex);
        logic [31:0] q;
        logic e;
        ctir_host_model_inst.xfer(1'b0, a, 32'h0000_0000, 4'h0, q, e);
        chk(x, q);
        chk({31'h0000_0000, ex}, {31'h0000_0000, e});
    endtask : rd
    // Reset values, ignored writes and refused addresses.
    task automatic t_reset_ro;
        logic [7:0] idx[9];
        idx = '{CTIR_IDX_BRIDGE_PWR, CTIR_IDX_FIELD_PWR, CTIR_IDX_RX_PWR,
            CTIR_IDX_BATT, CTIR_IDX_INDIC, CTIR_IDX_FAULT, CTIR_IDX_HOST_EN,
            CTIR_IDX_RX_EN, CTIR_IDX_MISC_EN};
        foreach (idx[i])
        begin
            wr(aw(idx[i]), 32'hFFFF_FFFF, 4'hE);
            rd(aw(idx[i]), 32'h0000_0000, 1'b0);
        end
        rd(12'h004, 32'h0000_0000, 1'b1);
        rd(12'h161, 32'h0000_0000, 1'b1);
    endtask : t_reset_ro
    // Telemetry readback, every fault code and every indicator code.
    task automatic t_telem;
        logic [7:0] p;
        telem <= '{16'h1234, 16'hBEEF, 16'h0ACE, 8'h64, 4'h0, 8'h00, 8'h00};
        wr(aw(CTIR_IDX_FIELD_PWR), 32'h0000_5555, 4'hF);
        rd(aw(CTIR_IDX_BRIDGE_PWR), 32'h0000_1234, 1'b0);
        rd(aw(CTIR_IDX_FIELD_PWR), 32'h0000_BEEF, 1'b0);
        rd(aw(CTIR_IDX_RX_PWR), 32'h0000_0ACE, 1'b0);
        rd(aw(CTIR_IDX_BATT), 32'h0000_0064, 1'b0);
        for (int i = 0; i <= 8; i++)
        begin
            p = (i == 8) ? CTIR_EPT_COMM : 8'(i * 17);
            telem.fault_code <= 8'(i);
            telem.fault_qualifier <= p;
            telem.indicator_code <= 4'(i % 7);
            rd(aw(CTIR_IDX_FAULT), {16'h0000, p, 8'(i)}, 1'b0);
            rd(aw(CTIR_IDX_INDIC), {28'h000_0000, 4'(i % 7)}, 1'b0);
        end
    endtask : t_telem
    // Each status source rises once under three mask settings.
    task automatic t_irq;
        logic [7:0] h;
        logic [7:0] r;
        logic e;
        int n;
        for (int m = 0; m < 3; m++)
        begin
            h = (m == 1) ? 8'h00 : 8'hFF;
            r = (m == 2) ? 8'h00 : 8'hFF;
            wr(aw(CTIR_IDX_HOST_EN), {24'h00_0000, h}, 4'hF);
            wr(aw(CTIR_IDX_RX_EN), {24'h00_0000, r}, 4'hF);
            wr(aw(CTIR_IDX_MISC_EN), {24'h00_0000, r}, 4'hF);
            rd(aw(CTIR_IDX_HOST_EN), {24'h00_0000, h & CTIR_HOST_EN_MASK},
                1'b0);
            rd(aw(CTIR_IDX_MISC_EN), {24'h00_0000, r & CTIR_MISC_EN_MASK},
                1'b0);
            for (int i = 0; i < 11; i++)
            begin
                e = (h != 0) && ((i >= 1 && i <= 8) ? (r != 0) : 1'b1);
                status <= ctir_status_t'(11'(1) << i);
                n = 0;
                for (int j = 0; j < 10; j++)
                begin
                    @(posedge clk_i);
                    n += int'(irq === 1'b1);
                    if (j == 4)
                        status <= '0;
                end
                chk({31'h0000_0000, e}, 32'(n));
            end
        end
    endtask : t_irq
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Reset, then the scenarios in turn.
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_ro();
        t_telem();
        t_irq();
        close_out();
    end
endmodule : tb_charger_telemetry_irq_regs
